/* bench/pmc_mac_model.sv */
/*
 * station management model: sends whole management frames on mdc and mdio.
 * assumes a pull-up on the data wire and a wire level worked out by the bench.
 */
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_mac_model (
    input  wire logic clk_in,
    input  wire logic mdio_wire_in,
    output logic      mdc_out,
    output logic      mdio_out,
    output logic      mdio_oe_out
);
    initial begin
        mdc_out     = 1'b0;
        mdio_out    = 1'b1;
        mdio_oe_out = 1'b0;
    end

    // four system cycles a phase, twice the minimum the engine needs
    task automatic bit_cycle(input logic drive, input logic b, output logic s);
        mdio_oe_out = drive;
        mdio_out    = b;
        mdc_out     = 1'b0;
        repeat (4) @(negedge clk_in);
        mdc_out = 1'b1;
        s       = mdio_wire_in;
        repeat (4) @(negedge clk_in);
    endtask : bit_cycle

    // full preamble every frame, the engine has no preamble suppression
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [45:0] hdr;
        logic        s;
        logic        wr;
        hdr = {32'hffff_ffff, 2'h1, op, phy, ra};
        wr  = (op == `PMC_OP_WRITE);
        for (int i = 45; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
        bit_cycle(wr, 1'b1, s);
        bit_cycle(wr, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wr, wdata[i], s);
            rdata[i] = s;
        end
        // clock stands still between frames
        mdio_oe_out = 1'b0;
        mdc_out     = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask : frame
endmodule : pmc_mac_model

/* bench/pmc_regs_monitor.sv */
/*
 * checker of the control outputs of the management register bank.
 * assumes it is bound to pmc_phy_mgmt_regs and straps stay steady during reset.
 */
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_regs_monitor (
    input wire logic       SYS_CLK_IN,
    input wire logic       RST_N_IN,
    input wire logic       MDC_IN,
    input wire logic       MDIO_OUT,
    input wire logic       MDIO_OE_OUT,
    input wire logic [2:0] HW_CONFIG_PINS_IN,
    input wire logic       SPEED_100_OUT,
    input wire logic       FULL_DUPLEX_OUT,
    input wire logic       AUTONEG_EN_OUT,
    input wire logic       LOOPBACK_OUT,
    input wire logic       ISOLATE_OUT,
    input wire logic       SOFT_RESET_OUT,
    input wire logic       RESTART_AN_OUT
);
    localparam int SR_CYC = `PMC_SOFT_RESET_CYC;
    logic [7:0] sr_cnt;
    logic [7:0] next_sr_cnt;

    always_comb next_sr_cnt = SOFT_RESET_OUT ? sr_cnt + 8'h01 : 8'h00;
    always_ff @(posedge SYS_CLK_IN) sr_cnt <= RST_N_IN ? next_sr_cnt : 8'h00;

    // reset checks carry no disable, they watch the reset itself
    AST_STRAP_LOAD: assert property (@(posedge SYS_CLK_IN) !RST_N_IN |=>
        AUTONEG_EN_OUT == $past(HW_CONFIG_PINS_IN[2]) && SPEED_100_OUT ==
        $past(HW_CONFIG_PINS_IN[1]) && FULL_DUPLEX_OUT == $past(HW_CONFIG_PINS_IN[0]))
        else $error("mode bits not loaded from straps");
    AST_MODES_RESET: assert property (@(posedge SYS_CLK_IN) !RST_N_IN |=>
        !ISOLATE_OUT && !LOOPBACK_OUT && !SOFT_RESET_OUT && !RESTART_AN_OUT)
        else $error("isolate or loopback set after reset");
    AST_RESTART_PULSE: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $rose(RESTART_AN_OUT) |=> !RESTART_AN_OUT)
        else $error("restart command did not clear itself");
    AST_SOFT_LEN: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $fell(SOFT_RESET_OUT) |-> sr_cnt == SR_CYC)
        else $error("soft reset length wrong");
    AST_SOFT_MAX: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        sr_cnt <= SR_CYC)
        else $error("soft reset does not clear itself");
    AST_SOFT_RELOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $rose(SOFT_RESET_OUT) |-> ##[0:2] (!LOOPBACK_OUT && !ISOLATE_OUT &&
        AUTONEG_EN_OUT == HW_CONFIG_PINS_IN[2]))
        else $error("soft reset did not reload defaults");
    AST_TA_LOW: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $rose(MDIO_OE_OUT) |-> !MDIO_OUT && !MDC_IN)
        else $error("turnaround drive wrong");
endmodule : pmc_regs_monitor

bind pmc_phy_mgmt_regs pmc_regs_monitor pmc_regs_monitor_inst (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .MDC_IN(MDC_IN), .MDIO_OUT(MDIO_OUT),
    .MDIO_OE_OUT(MDIO_OE_OUT), .HW_CONFIG_PINS_IN(HW_CONFIG_PINS_IN),
    .SPEED_100_OUT(SPEED_100_OUT), .FULL_DUPLEX_OUT(FULL_DUPLEX_OUT),
    .AUTONEG_EN_OUT(AUTONEG_EN_OUT), .LOOPBACK_OUT(LOOPBACK_OUT), .ISOLATE_OUT(ISOLATE_OUT),
    .SOFT_RESET_OUT(SOFT_RESET_OUT), .RESTART_AN_OUT(RESTART_AN_OUT));

/* bench/test_phy_mgmt_control_regs.sv */
/*
 * self-checking bench of the management register bank, driven over the serial pins.
 * assumes pmc_mac_model as station manager and a pull-up on the data wire.
 */
`timescale 1ns/1ps
`include "pmc_params.svh"

module test_phy_mgmt_control_regs;
    localparam logic [4:0] PHY = 5'h05;
    logic        clk, rst_n, mdc, mac_out, mac_oe, mdio_out, mdio_oe, mdio_wire;
    logic        spd, fdx, ane, lpb, pdn, iso, col, srst, rsan;
    logic [2:0]  straps;
    logic [15:0] port_cfg, int_mask, ind_set, dig_set, tx_ctrl, rd;
    int          n_errors, samples_checked, rsan_cnt, srst_cnt, i;

    assign mdio_wire = mdio_oe ? mdio_out : (mac_oe ? mac_out : 1'b1);

    pmc_phy_mgmt_regs pmc_phy_mgmt_regs_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .MDC_IN(mdc), .MDIO_IN(mdio_wire), .MDIO_OUT(mdio_out), .MDIO_OE_OUT(mdio_oe),
        .PHY_ADDR_IN(PHY), .HW_CONFIG_PINS_IN(straps), .SECONDARY_STATUS_IN(16'ha5c3),
        .INTERRUPT_CAUSE_IN(16'h3c5a), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fdx),
        .AUTONEG_EN_OUT(ane), .LOOPBACK_OUT(lpb), .POWER_DOWN_OUT(pdn), .ISOLATE_OUT(iso),
        .COLLISION_TEST_OUT(col), .SOFT_RESET_OUT(srst), .RESTART_AN_OUT(rsan),
        .PORT_CONFIG_OUT(port_cfg), .INTERRUPT_MASK_OUT(int_mask),
        .INDICATOR_SETUP_OUT(ind_set), .DIGITAL_SETUP_OUT(dig_set),
        .TRANSMITTER_CONTROL_OUT(tx_ctrl));
    pmc_mac_model pmc_mac_model_inst (.clk_in(clk), .mdio_wire_in(mdio_wire), .mdc_out(mdc),
        .mdio_out(mac_out), .mdio_oe_out(mac_oe));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rsan === 1'b1) rsan_cnt++;
        if (srst === 1'b1) srst_cnt++;
    end

    task automatic give_verdict();
        $display("checked %0d values, %0d wrong", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        pmc_mac_model_inst.frame(`PMC_OP_WRITE, PHY, a, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
        pmc_mac_model_inst.frame(`PMC_OP_READ, PHY, a, 16'h0000, rd);
        check(rd, exp, what);
    endtask : rd_chk

    task automatic test_reset(input logic [2:0] s);
        straps = s;
        rst_n  = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({ane, spd, fdx}, s, "strap modes");
        check({lpb, iso, pdn, col, srst, rsan}, 16'h0000, "reset modes");
        check(port_cfg | int_mask | ind_set | dig_set | tx_ctrl, `PMC_VENDOR_RST, "vendor");
        rd_chk(`PMC_ADDR_CTRL, {2'h0, s[1], s[2], 3'h0, s[0], 8'h00}, "ctrl reset");
        $display("test reset done");
    endtask : test_reset

    task automatic test_modes();
        logic [15:0] w [2];
        // only the 10 and 100 codes are written, the other two fall back to 10 Mbps
        w = '{16'h5dbf, 16'h2000};
        for (i = 0; i < 2; i++) begin
            wr(`PMC_ADDR_CTRL, w[i]);
            rd_chk(`PMC_ADDR_CTRL, w[i] & 16'hffc0, "ctrl readback");
            check(spd, !w[i][`PMC_BIT_SPEED_HI] && w[i][`PMC_BIT_SPEED_LO], "speed");
            check(lpb, w[i][`PMC_BIT_LOOPBACK], "loopback");
            check(iso, w[i][`PMC_BIT_ISOLATE], "isolate");
            check({ane, pdn, fdx, col}, {w[i][12:11], w[i][8:7]}, "modes");
        end
        $display("test modes done");
    endtask : test_modes

    task automatic test_commands();
        rsan_cnt = 0;
        wr(`PMC_ADDR_CTRL, 16'h2200);
        check(16'(rsan_cnt), 16'h0001, "restart pulse");
        rd_chk(`PMC_ADDR_CTRL, 16'h2000, "restart cleared");
        // straps change so the soft reset is seen to resample them
        straps   = 3'h5;
        srst_cnt = 0;
        wr(`PMC_ADDR_CTRL, 16'hc000);
        for (i = 0; i < 300 && srst === 1'b1; i++) @(negedge clk);
        if (i == 300) begin
            n_errors++;
            give_verdict();
        end
        check(16'(srst_cnt), 16'(`PMC_SOFT_RESET_CYC), "soft reset cycles");
        check({lpb, ane, fdx, spd}, 16'h0006, "soft reset modes");
        rd_chk(`PMC_ADDR_CTRL, 16'h1100, "soft reset cleared");
        $display("test commands done");
    endtask : test_commands

    task automatic test_vendor();
        logic [4:0] a [5];
        a = '{`PMC_ADDR_PORT_CFG, `PMC_ADDR_INT_MASK, `PMC_ADDR_INDICATOR,
              `PMC_ADDR_DIGITAL, `PMC_ADDR_TX_CTRL};
        for (i = 0; i < 5; i++) wr(a[i], 16'(16'h1111 * (i + 1)));
        check(port_cfg, 16'h1111, "port cfg");
        check(int_mask, 16'h2222, "int mask");
        check(ind_set, 16'h3333, "indicator");
        check(dig_set, 16'h4444, "digital");
        check(tx_ctrl, 16'h5555, "tx control");
        for (i = 0; i < 5; i++) rd_chk(a[i], 16'(16'h1111 * (i + 1)), "vendor read");
        wr(`PMC_ADDR_STATUS2, 16'hffff);
        rd_chk(`PMC_ADDR_STATUS2, 16'ha5c3, "status2");
        rd_chk(`PMC_ADDR_INT_CAUSE, 16'h3c5a, "int cause");
        rd_chk(5'h05, `PMC_READ_NONE, "unmapped");
        // a frame for another station must leave the bank and the wire alone
        pmc_mac_model_inst.frame(`PMC_OP_WRITE, 5'h06, `PMC_ADDR_PORT_CFG, 16'h0000, rd);
        pmc_mac_model_inst.frame(`PMC_OP_READ, 5'h06, `PMC_ADDR_PORT_CFG, 16'h0000, rd);
        check(rd, 16'hffff, "foreign read");
        check(port_cfg, 16'h1111, "foreign write");
        $display("test vendor done");
    endtask : test_vendor

    initial begin
        rst_n           = 1'b0;
        straps          = 3'h5;
        n_errors        = 0;
        samples_checked = 0;
        @(negedge clk);
        test_reset(3'h5);
        test_reset(3'h2);
        test_modes();
        test_commands();
        test_vendor();
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule : test_phy_mgmt_control_regs

/* design/pmc_mdio_serial.sv */
/*
 * management serial frame engine: decodes read and write frames, drives read data.
 * assumes mdc and mdio synchronous to clk_in, mdc slower than clk_in / 4.
 */
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_mdio_serial (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        mdc_in,
    input  wire logic        mdio_in,
    input  wire logic [4:0]  phy_addr_in,
    input  wire logic [15:0] rd_data_in,
    output logic             mdio_out,
    output logic             mdio_oe_out,
    output logic             wr_stb_out,
    output logic [4:0]       reg_addr_out,
    output logic [15:0]      wr_data_out
);
    pmc_pkg::pmc_frame_state_type state, next_state;
    logic [5:0]  cnt, next_cnt;
    logic [15:0] shift, next_shift;
    logic        is_read, next_is_read;
    logic        mdc_q;
    logic        next_mdio_out, next_mdio_oe, next_wr_stb;
    logic [4:0]  next_reg_addr;
    logic [15:0] next_wr_data;
    logic        rise, fall;
    logic [11:0] cmd;

    always_comb begin
        rise = mdc_in & ~mdc_q;
        fall = ~mdc_in & mdc_q;
        cmd = {shift[10:0], mdio_in};
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_is_read = is_read;
        next_mdio_out = mdio_out;
        next_mdio_oe = mdio_oe_out;
        next_wr_stb = 1'b0;
        next_reg_addr = reg_addr_out;
        next_wr_data = wr_data_out;
        if (rise) begin
            unique case (state)
                pmc_pkg::PMC_PRE: begin
                    if (mdio_in) begin
                        if (cnt != `PMC_PREAMBLE_BITS) next_cnt = cnt + 6'h01;
                    end else if (cnt == `PMC_PREAMBLE_BITS) begin
                        next_state = pmc_pkg::PMC_START;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
                pmc_pkg::PMC_START: begin
                    next_cnt = 6'h00;
                    next_state = mdio_in ? pmc_pkg::PMC_CMD : pmc_pkg::PMC_PRE;
                end
                pmc_pkg::PMC_CMD: begin
                    next_shift = {shift[14:0], mdio_in};
                    next_cnt = cnt + 6'h01;
                    if (cnt == `PMC_CMD_LAST) begin
                        next_cnt = 6'h00;
                        // frames for another station or with a bad opcode are dropped
                        if (cmd[9:5] == phy_addr_in &&
                            (cmd[11:10] == `PMC_OP_WRITE || cmd[11:10] == `PMC_OP_READ)) begin
                            next_state = pmc_pkg::PMC_TA;
                            next_is_read = (cmd[11:10] == `PMC_OP_READ);
                            next_reg_addr = cmd[4:0];
                        end else begin
                            next_state = pmc_pkg::PMC_PRE;
                        end
                    end
                end
                pmc_pkg::PMC_TA: begin
                    next_cnt = cnt + 6'h01;
                    if (cnt == `PMC_TA_LAST) begin
                        next_cnt = 6'h00;
                        next_state = pmc_pkg::PMC_DATA;
                    end
                end
                pmc_pkg::PMC_DATA: begin
                    if (!is_read) next_shift = {shift[14:0], mdio_in};
                    next_cnt = cnt + 6'h01;
                    if (cnt == `PMC_DATA_LAST) begin
                        next_cnt = 6'h00;
                        next_state = pmc_pkg::PMC_PRE;
                        if (!is_read) begin
                            next_wr_data = {shift[14:0], mdio_in};
                            next_wr_stb = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = pmc_pkg::PMC_PRE;
                    next_cnt = 6'h00;
                end
            endcase
        end
        if (fall) begin
            // first turnaround bit stays released, second is driven low
            next_mdio_oe = is_read && ((state == pmc_pkg::PMC_TA && cnt == `PMC_TA_LAST) ||
                                       state == pmc_pkg::PMC_DATA);
            next_mdio_out = 1'b0;
            if (state == pmc_pkg::PMC_TA && cnt == 6'h00 && is_read) next_shift = rd_data_in;
            if (state == pmc_pkg::PMC_DATA && is_read) begin
                next_mdio_out = shift[15];
                next_shift = {shift[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= pmc_pkg::PMC_PRE;
            cnt <= 6'h00;
            shift <= 16'h0000;
            is_read <= 1'b0;
            mdc_q <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe_out <= 1'b0;
            wr_stb_out <= 1'b0;
            reg_addr_out <= 5'h00;
            wr_data_out <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            is_read <= next_is_read;
            mdc_q <= mdc_in;
            mdio_out <= next_mdio_out;
            mdio_oe_out <= next_mdio_oe;
            wr_stb_out <= next_wr_stb;
            reg_addr_out <= next_reg_addr;
            wr_data_out <= next_wr_data;
        end
    end
endmodule : pmc_mdio_serial

/* design/pmc_params.svh */
/*
 * constants of the management register bank: register addresses, control bit
 * positions, strap pin positions, reset values and timing counts.
 * assumes a 100 MHz system clock and the standard two-wire management frame.
 */
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_ADDR_CTRL        5'h00
`define PMC_ADDR_PORT_CFG    5'h10
`define PMC_ADDR_STATUS2     5'h11
`define PMC_ADDR_INT_MASK    5'h12
`define PMC_ADDR_INT_CAUSE   5'h13
`define PMC_ADDR_INDICATOR   5'h14
`define PMC_ADDR_DIGITAL     5'h1a
`define PMC_ADDR_TX_CTRL     5'h1e

`define PMC_BIT_RESET        15
`define PMC_BIT_LOOPBACK     14
`define PMC_BIT_SPEED_LO     13
`define PMC_BIT_AN_EN        12
`define PMC_BIT_POWER_DOWN   11
`define PMC_BIT_ISOLATE      10
`define PMC_BIT_RESTART_AN   9
`define PMC_BIT_DUPLEX       8
`define PMC_BIT_COL_TEST     7
`define PMC_BIT_SPEED_HI     6
`define PMC_CTRL_RSVD_ZERO   6'h00

`define PMC_STRAP_AN_EN      2
`define PMC_STRAP_SPEED_LO   1
`define PMC_STRAP_DUPLEX     0

`define PMC_VENDOR_RST       16'h0000
`define PMC_VENDOR_COUNT     5
`define PMC_READ_NONE        16'h0000

`define PMC_PREAMBLE_BITS    6'h20
`define PMC_CMD_LAST         6'h0b
`define PMC_TA_LAST          6'h01
`define PMC_DATA_LAST        6'h0f
`define PMC_OP_WRITE         2'h1
`define PMC_OP_READ          2'h2

`define PMC_CLK_PERIOD_NS    10
`define PMC_SOFT_RESET_NS    1000
`define PMC_SOFT_RESET_CYC   ((`PMC_SOFT_RESET_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

/* design/pmc_phy_mgmt_regs.sv */
/*
 * management register bank of a 10/100 transceiver: basic control register and
 * the vendor register map, reached over the management serial pins.
 * assumes strap pins and status inputs synchronous to SYS_CLK_IN.
 */
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_phy_mgmt_regs (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        MDC_IN,
    input  wire logic        MDIO_IN,
    output logic             MDIO_OUT,
    output logic             MDIO_OE_OUT,
    input  wire logic [4:0]  PHY_ADDR_IN,
    input  wire logic [2:0]  HW_CONFIG_PINS_IN,
    input  wire logic [15:0] SECONDARY_STATUS_IN,
    input  wire logic [15:0] INTERRUPT_CAUSE_IN,
    output logic             SPEED_100_OUT,
    output logic             FULL_DUPLEX_OUT,
    output logic             AUTONEG_EN_OUT,
    output logic             LOOPBACK_OUT,
    output logic             POWER_DOWN_OUT,
    output logic             ISOLATE_OUT,
    output logic             COLLISION_TEST_OUT,
    output logic             SOFT_RESET_OUT,
    output logic             RESTART_AN_OUT,
    output logic [15:0]      PORT_CONFIG_OUT,
    output logic [15:0]      INTERRUPT_MASK_OUT,
    output logic [15:0]      INDICATOR_SETUP_OUT,
    output logic [15:0]      DIGITAL_SETUP_OUT,
    output logic [15:0]      TRANSMITTER_CONTROL_OUT
);
    // soft reset length is rounded up to whole clock cycles
    localparam logic [7:0] RESET_CYC = 8'(`PMC_SOFT_RESET_CYC);

    logic        wr_stb;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] read_word, next_read_word;

    logic        loopback, next_loopback;
    logic        speed_lo, next_speed_lo;
    logic        an_en, next_an_en;
    logic        power_down, next_power_down;
    logic        isolate, next_isolate;
    logic        duplex, next_duplex;
    logic        col_test, next_col_test;
    logic        speed_hi, next_speed_hi;
    logic        speed_100, next_speed_100;
    logic        reset_busy, next_reset_busy;
    logic        restart_an, next_restart_an;
    logic [7:0]  reset_cnt, next_reset_cnt;
    logic [15:0] vend [`PMC_VENDOR_COUNT];
    logic [15:0] next_vend [`PMC_VENDOR_COUNT];
    logic [3:0]  wr_hit, rd_hit;
    logic        ctrl_wr, load_defaults;

    // {hit, index} of a vendor read/write register
    function automatic logic [3:0] vend_slot(input logic [4:0] addr);
        unique case (addr)
            `PMC_ADDR_PORT_CFG:  vend_slot = 4'h8;
            `PMC_ADDR_INT_MASK:  vend_slot = 4'h9;
            `PMC_ADDR_INDICATOR: vend_slot = 4'ha;
            `PMC_ADDR_DIGITAL:   vend_slot = 4'hb;
            `PMC_ADDR_TX_CTRL:   vend_slot = 4'hc;
            default:             vend_slot = 4'h0;
        endcase
    endfunction : vend_slot

    pmc_mdio_serial pmc_mdio_serial_inst (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .mdc_in      (MDC_IN),
        .mdio_in     (MDIO_IN),
        .phy_addr_in (PHY_ADDR_IN),
        .rd_data_in  (read_word),
        .mdio_out    (MDIO_OUT),
        .mdio_oe_out (MDIO_OE_OUT),
        .wr_stb_out  (wr_stb),
        .reg_addr_out(reg_addr),
        .wr_data_out (wr_data)
    );

    // writes that land while a soft reset runs are dropped: the device is in reset
    always_comb begin
        wr_hit = vend_slot(reg_addr);
        rd_hit = vend_slot(reg_addr);
        ctrl_wr = wr_stb && !reset_busy && reg_addr == `PMC_ADDR_CTRL;
        load_defaults = ctrl_wr && wr_data[`PMC_BIT_RESET];
        next_loopback = loopback;
        next_speed_lo = speed_lo;
        next_an_en = an_en;
        next_power_down = power_down;
        next_isolate = isolate;
        next_duplex = duplex;
        next_col_test = col_test;
        next_speed_hi = speed_hi;
        next_restart_an = 1'b0;
        next_reset_busy = reset_busy;
        next_reset_cnt = reset_cnt;
        if (reset_busy) begin
            next_reset_cnt = reset_cnt - 8'h01;
            if (reset_cnt == 8'h00) next_reset_busy = 1'b0;
        end
        if (load_defaults) begin
            next_reset_busy = 1'b1;
            next_reset_cnt = RESET_CYC - 8'h01;
            next_loopback = 1'b0;
            next_power_down = 1'b0;
            next_isolate = 1'b0;
            next_col_test = 1'b0;
            next_speed_hi = 1'b0;
            next_an_en = HW_CONFIG_PINS_IN[`PMC_STRAP_AN_EN];
            next_speed_lo = HW_CONFIG_PINS_IN[`PMC_STRAP_SPEED_LO];
            next_duplex = HW_CONFIG_PINS_IN[`PMC_STRAP_DUPLEX];
        end else if (ctrl_wr) begin
            next_loopback = wr_data[`PMC_BIT_LOOPBACK];
            next_speed_lo = wr_data[`PMC_BIT_SPEED_LO];
            next_an_en = wr_data[`PMC_BIT_AN_EN];
            next_power_down = wr_data[`PMC_BIT_POWER_DOWN];
            next_isolate = wr_data[`PMC_BIT_ISOLATE];
            next_duplex = wr_data[`PMC_BIT_DUPLEX];
            next_col_test = wr_data[`PMC_BIT_COL_TEST];
            next_speed_hi = wr_data[`PMC_BIT_SPEED_HI];
            next_restart_an = wr_data[`PMC_BIT_RESTART_AN];
        end
        // the unsupported and reserved codes both fall back to 10 Mbps
        next_speed_100 = !next_speed_hi && next_speed_lo;
        // read word is registered: the frame engine latches it cycles after the address
        if (reg_addr == `PMC_ADDR_CTRL) begin
            next_read_word = {reset_busy, loopback, speed_lo, an_en, power_down, isolate,
                              restart_an, duplex, col_test, speed_hi,
                              `PMC_CTRL_RSVD_ZERO};
        end else if (reg_addr == `PMC_ADDR_STATUS2) begin
            next_read_word = SECONDARY_STATUS_IN;
        end else if (reg_addr == `PMC_ADDR_INT_CAUSE) begin
            next_read_word = INTERRUPT_CAUSE_IN;
        end else if (rd_hit[3]) begin
            next_read_word = vend[rd_hit[2:0]];
        end else begin
            next_read_word = `PMC_READ_NONE;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            loopback <= 1'b0;
            isolate <= 1'b0;
            an_en <= HW_CONFIG_PINS_IN[`PMC_STRAP_AN_EN];
            speed_lo <= HW_CONFIG_PINS_IN[`PMC_STRAP_SPEED_LO];
            duplex <= HW_CONFIG_PINS_IN[`PMC_STRAP_DUPLEX];
            speed_100 <= HW_CONFIG_PINS_IN[`PMC_STRAP_SPEED_LO];
            power_down <= 1'b0;
            col_test <= 1'b0;
            speed_hi <= 1'b0;
            restart_an <= 1'b0;
            reset_busy <= 1'b0;
            reset_cnt <= 8'h00;
            read_word <= 16'h0000;
        end else begin
            loopback <= next_loopback;
            isolate <= next_isolate;
            an_en <= next_an_en;
            speed_lo <= next_speed_lo;
            duplex <= next_duplex;
            speed_100 <= next_speed_100;
            power_down <= next_power_down;
            col_test <= next_col_test;
            speed_hi <= next_speed_hi;
            restart_an <= next_restart_an;
            reset_busy <= next_reset_busy;
            reset_cnt <= next_reset_cnt;
            read_word <= next_read_word;
        end
    end

    // vendor words are plain storage, field meanings are handled outside this bank
    genvar gi;
    generate
        for (gi = 0; gi < `PMC_VENDOR_COUNT; gi++) begin : g_vend
            always_comb begin
                next_vend[gi] = vend[gi];
                if (load_defaults) begin
                    next_vend[gi] = `PMC_VENDOR_RST;
                end else if (wr_stb && !reset_busy && wr_hit == {1'b1, 3'(gi)}) begin
                    next_vend[gi] = wr_data;
                end
            end
            always_ff @(posedge SYS_CLK_IN) begin
                if (!RST_N_IN) begin
                    vend[gi] <= `PMC_VENDOR_RST;
                end else begin
                    vend[gi] <= next_vend[gi];
                end
            end
        end
    endgenerate

    assign SPEED_100_OUT = speed_100;
    assign FULL_DUPLEX_OUT = duplex;
    assign AUTONEG_EN_OUT = an_en;
    assign LOOPBACK_OUT = loopback;
    assign POWER_DOWN_OUT = power_down;
    assign ISOLATE_OUT = isolate;
    assign COLLISION_TEST_OUT = col_test;
    assign SOFT_RESET_OUT = reset_busy;
    assign RESTART_AN_OUT = restart_an;
    assign PORT_CONFIG_OUT = vend[0];
    assign INTERRUPT_MASK_OUT = vend[1];
    assign INDICATOR_SETUP_OUT = vend[2];
    assign DIGITAL_SETUP_OUT = vend[3];
    assign TRANSMITTER_CONTROL_OUT = vend[4];
endmodule : pmc_phy_mgmt_regs

/* design/pmc_pkg.sv */
/*
 * types of the management register bank.
 * assumes pmc_params.svh for all numeric constants.
 */
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_PRE   = 3'h0,
        PMC_START = 3'h1,
        PMC_CMD   = 3'h2,
        PMC_TA    = 3'h3,
        PMC_DATA  = 3'h4
    } pmc_frame_state_type;
endpackage : pmc_pkg
